/* oss_pkg.sv */
// Purpose: Constants and types for the oscillator source select block
// Assumes: 25 MHz system clock, 32-bit register port
// Notes: Field positions are carried by the packed register structs
package oss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OSS_CLK_PERIOD_NS = 40;
  localparam int OSS_VER_TIMEOUT_NS = 1000;
  localparam int OSS_VER_CYCLES =
    (OSS_VER_TIMEOUT_NS + OSS_CLK_PERIOD_NS - 1) / OSS_CLK_PERIOD_NS;
  localparam int OSS_VCNT_W = 6;
  localparam int OSS_NOSC = 2;
  localparam int OSS_MAIN = 0;
  localparam int OSS_INT = 1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int OSS_AW = 12;
  localparam logic [11:0] OSS_ADDR_RCC = 12'h060;
  localparam logic [11:0] OSS_ADDR_PLLX = 12'h064;
  localparam logic [11:0] OSS_ADDR_STAT = 12'h068;
  localparam int OSS_RCC_W = 14;
  localparam logic [3:0] OSS_CRYSTAL_VALUE_MIN = 4'h4;

  typedef struct packed {
    logic pll_power_down;
    logic oen_n;
    logic [1:0] gap;
    logic [3:0] crystal_value;
    logic [1:0] src;
    logic iver;
    logic mver;
    logic idis;
    logic mdis;
  } oss_rcc_t;

  localparam logic [13:0] OSS_RCC_RST = 14'h32C0;

  typedef struct packed {
    logic [1:0] od;
    logic [8:0] f;
    logic [4:0] r;
  } oss_pllx_t;

  typedef enum logic [1:0] {
    OSS_SRC_MAIN = 2'b00,
    OSS_SRC_INT = 2'b01,
    OSS_SRC_INT4 = 2'b10,
    OSS_SRC_RSVD = 2'b11
  } oss_src_t;

  typedef enum logic [1:0] {
    OSS_PLL_PDN = 2'b00,
    OSS_PLL_NORMAL = 2'b01,
    OSS_PLL_OUTOFF = 2'b10
  } oss_pll_mode_t;

  typedef enum logic [1:0] {
    OSS_V_OFF = 2'b00,
    OSS_V_WATCH = 2'b01,
    OSS_V_FAIL = 2'b10
  } oss_vstate_t;

  // Crystal code to PLL divider settings; reserved codes give zero
  function automatic oss_pllx_t oss_xlate(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h4: v = 16'h1E03;
      4'h5: v = 16'h1F03;
      4'h6: v = 16'h1883;
      4'h7: v = 16'h1863;
      4'h8: v = 16'h1443;
      4'h9: v = 16'h13E3;
      4'hA: v = 16'h1383;
      4'hB: v = 16'h10A3;
      4'hC: v = 16'h1043;
      4'hD: v = 16'h0DA3;
      4'hE: v = 16'h0C83;
      4'hF: v = 16'h0C43;
      default: v = 16'h0000;
    endcase
    return oss_pllx_t'(v);
  endfunction : oss_xlate

endpackage : oss_pkg

/* oss_top.sv */
// Purpose: Oscillator source select, enables, verify timers, PLL mode
// Assumes: Oscillator pins are asynchronous to CLK and slower than CLK/2
// Notes: Register port answers reads one cycle later, never stalls
`timescale 1ns/10ps
`default_nettype none

module oss_top
  import oss_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic MOSC_CLK,
  input wire logic IOSC_CLK,
  output logic MAIN_OSC_EN,
  output logic INT_OSC_EN,
  output oss_src_t OSC_SRC,
  output logic CRYSTAL_VALUE_RSVD,
  output logic PLL_PLL_POWER_DOWN,
  output logic PLL_OE_N,
  output oss_pll_mode_t PLL_MODE,
  output oss_pllx_t PLL_CFG,
  output logic MOSC_FAIL_IRQ,
  output logic IOSC_FAIL_IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  oss_rcc_t rcc_r;
  oss_rcc_t rcc_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [OSS_NOSC-1:0] osc_pin;
  logic [OSS_NOSC-1:0] ver_en;
  logic [OSS_NOSC-1:0] fail_r;
  oss_vstate_t vst_r [OSS_NOSC];
  logic [OSS_VCNT_W-1:0] vcnt_r [OSS_NOSC];
  logic [OSS_NOSC-1:0] osc_edge;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    return a == target;
  endfunction : hit

  function automatic oss_pll_mode_t pll_mode(input logic pd, input logic oen_n);
    if (pd) begin
      return OSS_PLL_PDN;
    end
    return oen_n ? OSS_PLL_OUTOFF : OSS_PLL_NORMAL;
  endfunction : pll_mode

  // ----------------------------------------------------------------
  // Clock configuration register
  // ----------------------------------------------------------------
  always_comb begin
    rcc_nxt = rcc_r;
    if (WR && hit(ADDR, OSS_ADDR_RCC)) begin
      rcc_nxt = oss_rcc_t'(WDATA[OSS_RCC_W-1:0]);
      // Bypass and PLL verify bits live elsewhere
      rcc_nxt.gap = 2'b00;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rcc_r <= oss_rcc_t'(OSS_RCC_RST);
    end else begin
      rcc_r <= rcc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (RD) begin
      if (hit(ADDR, OSS_ADDR_RCC)) begin
        rdata_nxt = {18'h0_0000, rcc_r};
      end else if (hit(ADDR, OSS_ADDR_PLLX)) begin
        rdata_nxt = {16'h0000, PLL_CFG};
      end else if (hit(ADDR, OSS_ADDR_STAT)) begin
        rdata_nxt = {30'h0000_0000, fail_r};
      end
    end
  end

  // Data stands one cycle only, zero otherwise
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Registered from the next value so they track the register exactly
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MAIN_OSC_EN <= 1'b1;
      INT_OSC_EN <= 1'b1;
      OSC_SRC <= OSS_SRC_MAIN;
      CRYSTAL_VALUE_RSVD <= 1'b0;
      PLL_PLL_POWER_DOWN <= 1'b1;
      PLL_OE_N <= 1'b1;
      PLL_MODE <= OSS_PLL_PDN;
    end else begin
      MAIN_OSC_EN <= !rcc_nxt.mdis;
      INT_OSC_EN <= !rcc_nxt.idis;
      OSC_SRC <= oss_src_t'(rcc_nxt.src);
      CRYSTAL_VALUE_RSVD <= rcc_nxt.crystal_value < OSS_CRYSTAL_VALUE_MIN;
      PLL_PLL_POWER_DOWN <= rcc_nxt.pll_power_down;
      PLL_OE_N <= rcc_nxt.oen_n;
      PLL_MODE <= pll_mode(rcc_nxt.pll_power_down, rcc_nxt.oen_n);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PLL_CFG <= oss_xlate(OSS_RCC_RST[9:6]);
    end else if (rcc_nxt.crystal_value != rcc_r.crystal_value) begin
      PLL_CFG <= oss_xlate(rcc_nxt.crystal_value);
    end
  end

  // ----------------------------------------------------------------
  // Oscillator verification timers
  // ----------------------------------------------------------------
  assign osc_pin = {IOSC_CLK, MOSC_CLK};
  assign ver_en = {rcc_r.iver, rcc_r.mver};

  for (genvar i = 0; i < OSS_NOSC; i++) begin : g_ver
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Synchroniser first stage feeds only the second
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= osc_pin[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    assign osc_edge[i] = s2_r ^ s3_r;

    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        vst_r[i] <= OSS_V_OFF;
        vcnt_r[i] <= '0;
        fail_r[i] <= 1'b0;
      end else if (!ver_en[i]) begin
        vst_r[i] <= OSS_V_OFF;
        vcnt_r[i] <= '0;
        fail_r[i] <= 1'b0;
      end else begin
        case (vst_r[i])
          OSS_V_OFF: begin
            vst_r[i] <= OSS_V_WATCH;
            vcnt_r[i] <= '0;
          end
          OSS_V_WATCH: begin
            if (osc_edge[i]) begin
              vcnt_r[i] <= '0;
            end else if (vcnt_r[i] == OSS_VCNT_W'(OSS_VER_CYCLES - 1)) begin
              vst_r[i] <= OSS_V_FAIL;
              fail_r[i] <= 1'b1;
            end else begin
              vcnt_r[i] <= vcnt_r[i] + 1'b1;
            end
          end
          // Held until software drops the enable bit
          OSS_V_FAIL: begin
            fail_r[i] <= 1'b1;
          end
          default: begin
            vst_r[i] <= OSS_V_OFF;
          end
        endcase
      end
    end
  end

  assign MOSC_FAIL_IRQ = fail_r[OSS_MAIN];
  assign IOSC_FAIL_IRQ = fail_r[OSS_INT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence rcc_write;
    WR && hit(ADDR, OSS_ADDR_RCC);
  endsequence

  sequence main_quiet;
    vst_r[OSS_MAIN] == OSS_V_WATCH && !osc_edge[OSS_MAIN]
      && vcnt_r[OSS_MAIN] == OSS_VCNT_W'(OSS_VER_CYCLES - 1);
  endsequence

  sequence int_quiet;
    vst_r[OSS_INT] == OSS_V_WATCH && !osc_edge[OSS_INT]
      && vcnt_r[OSS_INT] == OSS_VCNT_W'(OSS_VER_CYCLES - 1);
  endsequence

  crystal_value_write_a: assert property (
    rcc_write |=> rcc_r.crystal_value == $past(WDATA[9:6]))
    else $error("crystal field not written");

  crystal_value_rsvd_a: assert property (
    CRYSTAL_VALUE_RSVD == (rcc_r.crystal_value < OSS_CRYSTAL_VALUE_MIN))
    else $error("reserved crystal flag wrong");

  src_follow_a: assert property (
    rcc_write |=> OSC_SRC == oss_src_t'($past(WDATA[5:4])))
    else $error("source select not updated");

  int_fail_a: assert property (
    (ver_en[OSS_INT] && rcc_nxt.iver) and int_quiet |=> IOSC_FAIL_IRQ)
    else $error("internal oscillator failure missed");

  int_idle_a: assert property (
    !rcc_r.iver |=> !IOSC_FAIL_IRQ)
    else $error("internal check active while off");

  main_fail_a: assert property (
    (ver_en[OSS_MAIN] && rcc_nxt.mver) and main_quiet |=> MOSC_FAIL_IRQ)
    else $error("main oscillator failure missed");

  main_idle_a: assert property (
    !rcc_r.mver |=> !MOSC_FAIL_IRQ)
    else $error("main check active while off");

  main_early_a: assert property (
    $rose(MOSC_FAIL_IRQ) |-> $past(vcnt_r[OSS_MAIN])
      == OSS_VCNT_W'(OSS_VER_CYCLES - 1))
    else $error("main failure raised early");

  osc_gate_a: assert property (
    INT_OSC_EN == !rcc_r.idis && MAIN_OSC_EN == !rcc_r.mdis)
    else $error("oscillator gate mismatch");

  pll_pdn_a: assert property (
    rcc_r.pll_power_down |-> PLL_MODE == OSS_PLL_PDN)
    else $error("power-down not honoured");

  pll_run_a: assert property (
    (PLL_MODE == OSS_PLL_NORMAL) == (!PLL_PLL_POWER_DOWN && !PLL_OE_N))
    else $error("PLL run condition wrong");

  xlate_read_a: assert property (
    rcc_write ##1 RD && hit(ADDR, OSS_ADDR_PLLX)
      |=> RDATA[15:0] == 16'(oss_xlate($past(rcc_r.crystal_value))))
    else $error("translation not following crystal");

  rd_once_a: assert property (
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data held too long");

endmodule : oss_top

`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the oscillator source select block
// Assumes: Oscillator pins are driven here at a quarter of CLK
// Notes: Model holds the clock config word in an integer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import oss_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, mosc = 0, iosc = 0, ph = 0, mrun = 1, irun = 1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic men, ien, xr, pd, pll_output_enable_n, mirq, iirq;
  logic [15:0] prev;
  oss_src_t src;
  oss_pll_mode_t mode;
  oss_pllx_t cfg;
  integer n_mismatch = 0, tests_run = 0, cyc = 0, seed = 32'h4ca2, i, n, k, m_rcc;
  always #20 clk = ~clk;
  oss_top dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MOSC_CLK(mosc), .IOSC_CLK(iosc), .MAIN_OSC_EN(men), .INT_OSC_EN(ien),
    .OSC_SRC(src), .CRYSTAL_VALUE_RSVD(xr), .PLL_PLL_POWER_DOWN(pd), .PLL_OE_N(pll_output_enable_n), .PLL_MODE(mode),
    .PLL_CFG(cfg), .MOSC_FAIL_IRQ(mirq), .IOSC_FAIL_IRQ(iirq));
  // ----------------------------------------------------------------
  // Oscillator pins and hang guard
  // ----------------------------------------------------------------
  // Toggle every other cycle, slow enough for the pin synchronisers
  always @(posedge clk) begin
    ph <= ~ph;
    if (ph && mrun) mosc <= ~mosc;
    if (ph && irun) iosc <= ~iosc;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr
  // Read data stands one cycle only, then returns to zero
  task automatic bus_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
    #1 chk(rdata, 32'h0000_0000);
  endtask : bus_rd
  task automatic chk_out();
    logic [31:0] r;
    r = m_rcc;
    chk({men, ien, src, xr, pd, pll_output_enable_n, mode}, {~r[0], ~r[1], r[5:4], r[9:6] < 4'h4, r[13], r[12],
      r[13] ? OSS_PLL_PDN : (r[12] ? OSS_PLL_OUTOFF : OSS_PLL_NORMAL)});
  endtask : chk_out
  task automatic chk_reset();
    m_rcc = 32'h0000_32C0;
    #1 chk_out();
    chk({mirq, iirq, cfg}, 32'h0000_10A3);
    bus_rd(OSS_ADDR_RCC, 32'h0000_32C0);
  endtask : chk_reset
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk_reset();
    // random words avoid reserved source code
    for (i = 0; i < 40; i++) begin
      k = $random(seed);
      if (k[5:4] == 2'b11) k[5] = 1'b0;
      m_rcc = k & 32'h0000_33FF;
      bus_wr(OSS_ADDR_RCC, k);
      chk_out();
      chk({mirq, iirq}, 32'h0000_0000);
      bus_rd(OSS_ADDR_RCC, m_rcc);
    end
    // Writes elsewhere must leave the config word alone
    bus_wr(OSS_ADDR_PLLX, 32'hFFFF_FFFF);
    bus_wr(12'h0F0, 32'hFFFF_FFFF);
    bus_rd(12'h0F0, 32'h0000_0000);
    bus_rd(OSS_ADDR_RCC, m_rcc);
    for (i = 0; i < 16; i++) begin
      prev = cfg;
      m_rcc = (m_rcc & 32'h0000_303F) | (i << 6);
      bus_wr(OSS_ADDR_RCC, m_rcc);
      chk_out();
      chk((i < 4) ? (cfg === 16'h0000) : (i == 4 || cfg !== prev), 32'h0000_0001);
      chk(cfg, oss_xlate(i[3:0]));
    end
    m_rcc = 32'h0000_32E0;
    // internal over four for the PLL
    bus_wr(OSS_ADDR_RCC, m_rcc);
    chk_out();
    bus_rd(OSS_ADDR_PLLX, 32'h0000_10A3);
    for (i = 0; i < 2; i++) begin
      m_rcc = 32'h0000_32C0;
      bus_wr(OSS_ADDR_RCC, m_rcc);
      @(posedge clk);
      mrun <= (i != 0);
      irun <= (i != 1);
      repeat (40) @(posedge clk);
      #1 chk({mirq, iirq}, 32'h0000_0000);
      bus_wr(OSS_ADDR_RCC, m_rcc | (4 << i));
      n = 0;
      while ((i ? iirq : mirq) !== 1'b1 && n < 60) begin
        @(posedge clk);
        #1 n++;
      end
      chk(n > 15 && n < 60, 32'h0000_0001);
      chk({iirq, mirq}, 1 << i);
      bus_rd(OSS_ADDR_STAT, 1 << i);
      bus_wr(OSS_ADDR_RCC, m_rcc);
      @(posedge clk);
      #1 chk({mirq, iirq}, 32'h0000_0000);
      mrun <= 1'b1;
      irun <= 1'b1;
    end
    // Second reset in mid-run
    bus_wr(OSS_ADDR_RCC, 32'h0000_0DE3);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_reset();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
